// file: hdl/fsk_message_assembler.sv
// FSK message assembler: APB command port, checksum unit, bit serializer
`timescale 1ns/1ns
// Overview of operation
// - Clear sets checksum accumulator to zero
// - Add appends current checksum to message
// - Enabled accumulation updates on every appended byte except checksum bytes and second copies of repeated bytes
// - CRC select switches to 16-bit CRC
// - Modulo select switches to sum modulo 256
// - Integer operand loads accumulator directly
// - Increment adds, decrement subtracts operand
// - Frame start inserts type byte, tracks length
// - Field start inserts type byte, tracks length
// - Byte command appends bytes, most significant first
// - Byte command can append length plus offset
// - Two-byte value sent low byte first
// - Two-byte command can send length plus offset
// - Text characters encoded with active parity
// - Bit run appends n mark or space
// - Toggling run alternates bits, starting zero
// - Idle-line guard runs command only on-hook
// - Busy-line guard runs command only off-hook
// - Matching bytes sent twice while repeat set
// - Checksum never repeated; compare before parity
// - Parity mode gives seven data bits plus parity
// - One to one hundred stop bits
// - Start bit space, stop bits mark
// - Modulo checksum byte is negated sum
module fsk_message_assembler #(
  parameter logic [15:0] CRC_POLY = 16'h1021,
  parameter logic [15:0] CRC_INIT = 16'hFFFF
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line sense pin, high while off-hook
  input wire logic off_hook_pin,
  // Modulator side
  input wire logic baud_tick,
  output logic bit_out,
  output logic bit_valid
);

  typedef enum logic [2:0] {
    S_IDLE, S_LOAD, S_START, S_DATA, S_STOP, S_RUN
  } eng_t;

  // One CRC byte step, MSB first through the register
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ b[i];
      r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  // Parity encoding: low seven bits kept, bit 7 carries parity
  function automatic logic [7:0] par_enc(input logic [7:0] b,
                                         input logic [1:0] mode);
    logic [7:0] r;
    r = b;
    if (mode == fsk_asm_pkg::PAR_ODD) begin
      r = {~(^b[6:0]), b[6:0]};
    end else if (mode == fsk_asm_pkg::PAR_EVEN) begin
      r = {^b[6:0], b[6:0]};
    end
    return r;
  endfunction

  // APB state
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rd_d;
  logic [31:0] cmd_q; // Last command taken
  // Configuration
  logic [6:0] stop_bits_q;
  logic [1:0] parity_q;
  logic parity_all_q;
  logic dup_en_q;
  logic [7:0] dup_val_q;
  // Checksum unit and length tracking
  logic [15:0] ck_q;
  logic ck_on_q, crc_mode_q;
  logic [15:0] whole_frame_length_q, field_length_q;
  logic frame_open_q, field_open_q;
  // Pending bytes of the command in progress
  logic [7:0] pend_q [2];
  logic [1:0] pend_n_q;
  logic pend_ck_q, pend_txt_q, pend_skipw_q, pend_skipf_q;
  // Serializer
  eng_t eng_q;
  logic [7:0] tx_q;
  logic [2:0] bit_idx_q;
  logic [6:0] stop_cnt_q;
  logic [12:0] run_left_q;
  logic [1:0] run_kind_q;
  logic dup_q;
  logic bit_out_q, bit_valid_q;
  // Line sense synchroniser and filtered state
  logic [2:0] hook_sync_q;
  logic off_hook_q;

  // Command word split
  logic [4:0] op;
  logic [1:0] cond, sel;
  logic cnt;
  logic [15:0] dat;
  assign op = pwdata[fsk_asm_pkg::OP_MSB:fsk_asm_pkg::OP_LSB];
  assign cond = pwdata[fsk_asm_pkg::COND_MSB:fsk_asm_pkg::COND_LSB];
  assign sel = pwdata[fsk_asm_pkg::SEL_MSB:fsk_asm_pkg::SEL_LSB];
  assign cnt = pwdata[fsk_asm_pkg::CNT_POS];
  assign dat = pwdata[fsk_asm_pkg::DATA_MSB:0];

  logic access, is_cmd, mapped, busy, cond_ok, exec;
  assign access = psel & penable;
  assign is_cmd = (paddr == fsk_asm_pkg::CMD_OFFSET);
  assign mapped = is_cmd || (paddr == fsk_asm_pkg::STATUS_OFFSET) ||
                  (paddr == fsk_asm_pkg::CONFIG_OFFSET) ||
                  (paddr == fsk_asm_pkg::LENGTH_OFFSET);
  // Busy covers queued bytes so a new command never overtakes them
  assign busy = (eng_q != S_IDLE) || (pend_n_q != 2'd0);
  // Guard evaluated on the filtered line state
  always_comb begin
    unique case (cond)
      fsk_asm_pkg::COND_IDLE_LINE: cond_ok = !off_hook_q;
      fsk_asm_pkg::COND_BUSY_LINE: cond_ok = off_hook_q;
      default: cond_ok = (cond == fsk_asm_pkg::COND_NONE);
    endcase
  end
  // Command acts at the edge where the master sees pready
  assign exec = access & pready_q & pwrite & is_cmd & cond_ok;

  // Read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      fsk_asm_pkg::CMD_OFFSET: rd_d = cmd_q;
      fsk_asm_pkg::STATUS_OFFSET: begin
        rd_d[fsk_asm_pkg::ST_BUSY] = busy;
        rd_d[fsk_asm_pkg::ST_OFF_HOOK] = off_hook_q;
        rd_d[fsk_asm_pkg::ST_FRAME_OPEN] = frame_open_q;
        rd_d[fsk_asm_pkg::ST_FIELD_OPEN] = field_open_q;
        rd_d[fsk_asm_pkg::ST_CK_ON] = ck_on_q;
        rd_d[fsk_asm_pkg::ST_CRC] = crc_mode_q;
        rd_d[31:fsk_asm_pkg::ST_CK_LSB] = ck_q;
      end
      fsk_asm_pkg::CONFIG_OFFSET: begin
        rd_d[6:0] = stop_bits_q;
        rd_d[fsk_asm_pkg::CF_PAR_LSB +: 2] = parity_q;
        rd_d[fsk_asm_pkg::CF_PAR_ALL] = parity_all_q;
        rd_d[fsk_asm_pkg::CF_DUP_EN] = dup_en_q;
        rd_d[fsk_asm_pkg::CF_DUP_LSB +: 8] = dup_val_q;
      end
      fsk_asm_pkg::LENGTH_OFFSET:
        rd_d = {field_length_q, whole_frame_length_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // APB handshake; a command write waits while the engine is busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      cmd_q <= 32'h0000_0000;
    end else if (ce) begin
      if (access && !pready_q) begin
        if (!(pwrite && is_cmd && busy)) begin
          pready_q <= 1'b1;
          // Unmapped, or write to a read-only word
          pslverr_q <= !mapped || (pwrite && !is_cmd);
          prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        end
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
      if (access && pready_q && pwrite && is_cmd) begin
        cmd_q <= pwdata;
      end
    end
  end

  // Line sense: three stages, change taken when last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hook_sync_q <= 3'h0;
      off_hook_q <= 1'b0;
    end else if (ce) begin
      hook_sync_q <= {hook_sync_q[1:0], off_hook_pin};
      if (hook_sync_q[1] == hook_sync_q[2]) begin
        off_hook_q <= hook_sync_q[2];
      end
    end
  end

  // Configuration commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_bits_q <= fsk_asm_pkg::STOP_RESET;
      parity_q <= fsk_asm_pkg::PAR_NONE;
      parity_all_q <= 1'b0;
      dup_en_q <= 1'b0;
      dup_val_q <= 8'h00;
    end else if (ce && exec) begin
      // Out of range stop counts are ignored
      if (op == fsk_asm_pkg::OP_STOPBITS &&
          dat[6:0] >= fsk_asm_pkg::STOP_MIN &&
          dat[6:0] <= fsk_asm_pkg::STOP_MAX && dat[15:7] == 9'h000) begin
        stop_bits_q <= dat[6:0];
      end
      if (op == fsk_asm_pkg::OP_PARITY) begin
        parity_q <= dat[1:0];
        parity_all_q <= dat[fsk_asm_pkg::PAR_ALL_POS];
      end
      if (op == fsk_asm_pkg::OP_DUPLICATE) begin
        dup_en_q <= (sel != fsk_asm_pkg::SEL_START);
        dup_val_q <= dat[7:0];
      end
    end
  end

  // Bytes a command produces
  logic [1:0] q_n;
  logic [7:0] q_b0, q_b1;
  logic q_ck, q_txt, q_skipw, q_skipf;
  logic [15:0] len_sel;
  always_comb begin
    q_n = 2'd0;
    q_b0 = dat[7:0];
    q_b1 = dat[15:8];
    q_ck = 1'b0;
    q_txt = 1'b0;
    q_skipw = 1'b0;
    q_skipf = 1'b0;
    // Length plus signed offset, wraps in 16 bits
    len_sel = ((sel == fsk_asm_pkg::SEL_WHOLE) ? whole_frame_length_q :
               field_length_q) + dat;
    unique case (op)
      fsk_asm_pkg::OP_MESSAGE, fsk_asm_pkg::OP_PARAM: begin
        if (sel == fsk_asm_pkg::SEL_START) begin
          q_n = 2'd1;
          q_skipw = (op == fsk_asm_pkg::OP_MESSAGE);
          q_skipf = 1'b1;
        end
      end
      fsk_asm_pkg::OP_BYTE: begin
        if (sel == fsk_asm_pkg::SEL_LITERAL) begin
          // Two hex bytes go high byte first
          q_n = cnt ? 2'd2 : 2'd1;
          q_b0 = cnt ? dat[15:8] : dat[7:0];
          q_b1 = dat[7:0];
        end else begin
          q_n = 2'd1;
          q_b0 = len_sel[7:0];
        end
      end
      fsk_asm_pkg::OP_TWO_BYTE: begin
        q_n = 2'd2;
        if (sel != fsk_asm_pkg::SEL_LITERAL) begin
          q_b0 = len_sel[7:0];
          q_b1 = len_sel[15:8];
        end
      end
      fsk_asm_pkg::OP_CHAR: begin
        q_n = 2'd1;
        q_txt = 1'b1;
      end
      fsk_asm_pkg::OP_CK_ADD: begin
        q_ck = 1'b1;
        if (crc_mode_q) begin
          q_n = 2'd2;
          q_b0 = ck_q[7:0];
          q_b1 = ck_q[15:8];
        end else begin
          q_n = 2'd1;
          q_b0 = 8'h00 - ck_q[7:0];
        end
      end
      default: q_n = 2'd0;
    endcase
  end

  logic load;
  assign load = (eng_q == S_LOAD);

  // Pending byte queue, shifted as the serializer loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q[0] <= 8'h00;
      pend_q[1] <= 8'h00;
      pend_n_q <= 2'd0;
      pend_ck_q <= 1'b0;
      pend_txt_q <= 1'b0;
      pend_skipw_q <= 1'b0;
      pend_skipf_q <= 1'b0;
    end else if (ce) begin
      if (exec && q_n != 2'd0) begin
        pend_q[0] <= q_b0;
        pend_q[1] <= q_b1;
        pend_n_q <= q_n;
        pend_ck_q <= q_ck;
        pend_txt_q <= q_txt;
        pend_skipw_q <= q_skipw;
        pend_skipf_q <= q_skipf;
      end else if (load) begin
        pend_q[0] <= pend_q[1];
        pend_n_q <= pend_n_q - 2'd1;
        // Type byte is always a single byte
        pend_skipw_q <= 1'b0;
        pend_skipf_q <= 1'b0;
      end
    end
  end

  // Checksum unit and length counters
  logic [15:0] ck_arith;
  always_comb begin
    ck_arith = (op == fsk_asm_pkg::OP_CK_DEC) ? ck_q - dat : ck_q + dat;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_q <= fsk_asm_pkg::CK_RESET;
      ck_on_q <= 1'b0;
      crc_mode_q <= 1'b0;
      whole_frame_length_q <= 16'h0000;
      field_length_q <= 16'h0000;
      frame_open_q <= 1'b0;
      field_open_q <= 1'b0;
    end else if (ce) begin
      if (exec) begin
        unique case (op)
          fsk_asm_pkg::OP_CK_CLEAR: ck_q <= 16'h0000;
          fsk_asm_pkg::OP_CK_ON: ck_on_q <= 1'b1;
          fsk_asm_pkg::OP_CK_OFF: ck_on_q <= 1'b0;
          fsk_asm_pkg::OP_CK_CRC: begin
            crc_mode_q <= 1'b1;
            ck_q <= CRC_INIT;
          end
          fsk_asm_pkg::OP_CK_MOD: begin
            crc_mode_q <= 1'b0;
            ck_q <= {8'h00, ck_q[7:0]};
          end
          fsk_asm_pkg::OP_CK_LOAD:
            ck_q <= crc_mode_q ? dat : {8'h00, dat[7:0]};
          fsk_asm_pkg::OP_CK_INC, fsk_asm_pkg::OP_CK_DEC:
            ck_q <= crc_mode_q ? ck_arith : {8'h00, ck_arith[7:0]};
          fsk_asm_pkg::OP_MESSAGE: begin
            frame_open_q <= (sel == fsk_asm_pkg::SEL_START);
            if (sel == fsk_asm_pkg::SEL_START) begin
              whole_frame_length_q <= 16'h0000;
            end
          end
          fsk_asm_pkg::OP_PARAM: begin
            field_open_q <= (sel == fsk_asm_pkg::SEL_START);
            if (sel == fsk_asm_pkg::SEL_START) begin
              field_length_q <= 16'h0000;
            end
          end
          default: ck_q <= ck_q;
        endcase
      end else if (load && !pend_ck_q) begin
        // Checksum sees the byte before parity encoding
        if (ck_on_q) begin
          ck_q <= crc_mode_q ? crc_step(ck_q, pend_q[0]) :
                  {8'h00, ck_q[7:0] + pend_q[0]};
        end
        if (frame_open_q && !pend_skipw_q) begin
          whole_frame_length_q <= whole_frame_length_q + 16'h0001;
        end
        if (field_open_q && !pend_skipf_q) begin
          field_length_q <= field_length_q + 16'h0001;
        end
      end
    end
  end

  // Serializer: start, eight data bits, stop bits, or a bit run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_q <= S_IDLE;
      tx_q <= 8'h00;
      bit_idx_q <= 3'd0;
      stop_cnt_q <= 7'h00;
      run_left_q <= 13'h0000;
      run_kind_q <= fsk_asm_pkg::RUN_MARK;
      dup_q <= 1'b0;
      bit_out_q <= 1'b1;
      bit_valid_q <= 1'b0;
    end else if (ce) begin
      unique case (eng_q)
        S_IDLE: begin
          if (pend_n_q != 2'd0) begin
            eng_q <= S_LOAD;
          end else if (exec && op == fsk_asm_pkg::OP_BITS &&
                       dat[12:0] != 13'h0000 &&
                       dat[12:0] <= fsk_asm_pkg::RUN_MAX) begin
            eng_q <= S_RUN;
            run_left_q <= dat[12:0];
            run_kind_q <= sel;
            // Mark is 1; space and toggling runs open with 0
            bit_out_q <= (sel == fsk_asm_pkg::RUN_MARK);
            bit_valid_q <= 1'b1;
          end
        end
        S_LOAD: begin
          // Repeat compare on the raw byte, never on checksum bytes
          dup_q <= dup_en_q && !pend_ck_q &&
                   (pend_q[0] == dup_val_q);
          tx_q <= (!pend_ck_q && (pend_txt_q || parity_all_q)) ?
                  par_enc(pend_q[0], parity_q) : pend_q[0];
          eng_q <= S_START;
          bit_out_q <= 1'b0;
          bit_valid_q <= 1'b1;
        end
        S_START: begin
          if (baud_tick) begin
            eng_q <= S_DATA;
            bit_idx_q <= 3'd0;
            bit_out_q <= tx_q[0];
          end
        end
        S_DATA: begin
          if (baud_tick) begin
            if (bit_idx_q == 3'd7) begin
              eng_q <= S_STOP;
              stop_cnt_q <= 7'h01;
              bit_out_q <= 1'b1;
            end else begin
              bit_idx_q <= bit_idx_q + 3'd1;
              bit_out_q <= tx_q[bit_idx_q + 3'd1];
            end
          end
        end
        S_STOP: begin
          if (baud_tick) begin
            if (stop_cnt_q < stop_bits_q) begin
              stop_cnt_q <= stop_cnt_q + 7'h01;
            end else if (dup_q) begin
              // Second copy of the matched byte
              dup_q <= 1'b0;
              eng_q <= S_START;
              bit_out_q <= 1'b0;
            end else begin
              eng_q <= (pend_n_q != 2'd0) ? S_LOAD : S_IDLE;
              bit_valid_q <= 1'b0;
            end
          end
        end
        S_RUN: begin
          if (baud_tick) begin
            if (run_left_q == 13'h0001) begin
              eng_q <= S_IDLE;
              bit_valid_q <= 1'b0;
              bit_out_q <= 1'b1;
            end else begin
              run_left_q <= run_left_q - 13'h0001;
              if (run_kind_q == fsk_asm_pkg::RUN_TOGGLE) begin
                bit_out_q <= ~bit_out_q;
              end
            end
          end
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bit_out = bit_out_q;
  assign bit_valid = bit_valid_q;

endmodule

// file: hdl/fsk_asm_pkg.sv
// Constants shared by the FSK message assembler and its bench
package fsk_asm_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] CMD_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET = 8'h08;
  localparam logic [7:0] LENGTH_OFFSET = 8'h0C;
  // Command word fields
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 27;
  localparam int COND_MSB = 26;
  localparam int COND_LSB = 25;
  localparam int SEL_MSB = 24;
  localparam int SEL_LSB = 23;
  localparam int CNT_POS = 16;
  localparam int DATA_MSB = 15;
  // Opcodes
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_STOPBITS = 5'h01;
  localparam logic [4:0] OP_PARITY = 5'h02;
  localparam logic [4:0] OP_CK_CLEAR = 5'h03;
  localparam logic [4:0] OP_CK_ADD = 5'h04;
  localparam logic [4:0] OP_CK_ON = 5'h05;
  localparam logic [4:0] OP_CK_OFF = 5'h06;
  localparam logic [4:0] OP_CK_CRC = 5'h07;
  localparam logic [4:0] OP_CK_MOD = 5'h08;
  localparam logic [4:0] OP_CK_LOAD = 5'h09;
  localparam logic [4:0] OP_CK_INC = 5'h0A;
  localparam logic [4:0] OP_CK_DEC = 5'h0B;
  localparam logic [4:0] OP_MESSAGE = 5'h0C;
  localparam logic [4:0] OP_PARAM = 5'h0D;
  localparam logic [4:0] OP_BYTE = 5'h0E;
  localparam logic [4:0] OP_TWO_BYTE = 5'h0F;
  localparam logic [4:0] OP_CHAR = 5'h10;
  localparam logic [4:0] OP_BITS = 5'h11;
  localparam logic [4:0] OP_DUPLICATE = 5'h12;
  // Guard codes
  localparam logic [1:0] COND_NONE = 2'h0;
  localparam logic [1:0] COND_IDLE_LINE = 2'h1;
  localparam logic [1:0] COND_BUSY_LINE = 2'h2;
  // Selector codes
  localparam logic [1:0] SEL_LITERAL = 2'h0;
  localparam logic [1:0] SEL_WHOLE = 2'h1;
  localparam logic [1:0] SEL_FIELD = 2'h2;
  localparam logic [1:0] SEL_START = 2'h0;
  localparam logic [1:0] RUN_MARK = 2'h0;
  localparam logic [1:0] RUN_TOGGLE = 2'h2;
  // Parity codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam int PAR_ALL_POS = 2;
  // Limits and reset values
  localparam logic [6:0] STOP_MIN = 7'h01;
  localparam logic [6:0] STOP_MAX = 7'h64;
  localparam logic [6:0] STOP_RESET = 7'h01;
  localparam logic [12:0] RUN_MAX = 13'h1000;
  localparam logic [15:0] CK_RESET = 16'h0000;
  // Status and config bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_OFF_HOOK = 1;
  localparam int ST_FRAME_OPEN = 2;
  localparam int ST_FIELD_OPEN = 3;
  localparam int ST_CK_ON = 4;
  localparam int ST_CRC = 5;
  localparam int ST_CK_LSB = 16;
  localparam int CF_PAR_LSB = 8;
  localparam int CF_PAR_ALL = 10;
  localparam int CF_DUP_EN = 11;
  localparam int CF_DUP_LSB = 16;
endpackage

// file: sim/fsk_asm_props.sv
// Port assertions for the FSK message assembler
`timescale 1ns/1ns
module fsk_asm_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Modulator side
  input wire logic baud_tick,
  input wire logic bit_out,
  input wire logic bit_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle then an access still waiting for its answer
  sequence s_acc;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  // Register reads answer after one wait state
  property p_ans;
    s_acc ##0 paddr != fsk_asm_pkg::CMD_OFFSET |=> pready;
  endproperty
  // Answer stands a single cycle
  property p_pulse;
    pready |=> !pready;
  endproperty
  // Error only together with the answer
  property p_err;
    pslverr |-> pready;
  endproperty
  // Status word refuses writes
  property p_ro;
    s_acc ##0 pwrite && paddr == fsk_asm_pkg::STATUS_OFFSET
      |=> pready && pslverr;
  endproperty
  // Holes in the map give an error and zero data
  property p_hole;
    s_acc ##0 (paddr > 8'h0C || paddr[1:0] != 2'h0)
      |=> pslverr && prdata == 32'h0;
  endproperty
  // Writes return zero data
  property p_wzero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  // Line rests at mark while bit_valid is low
  property p_idle;
    !bit_valid |-> bit_out;
  endproperty
  // A bit only moves on after a baud tick
  property p_hold;
    bit_valid && $past(bit_valid) && !$past(baud_tick) |-> $stable(bit_out);
  endproperty
  // Stream ends only after a tick took the last bit
  property p_fall;
    $fell(bit_valid) |-> $past(baud_tick);
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  a_pulse: assert property (p_pulse) else $error("long answer");
  a_err: assert property (p_err) else $error("stray error");
  a_ro: assert property (p_ro) else $error("write not refused");
  a_hole: assert property (p_hole) else $error("hole not refused");
  a_wzero: assert property (p_wzero) else $error("write data not zero");
  a_idle: assert property (p_idle) else $error("idle not mark");
  a_hold: assert property (p_hold) else $error("bit moved");
  a_fall: assert property (p_fall) else $error("early end");
endmodule
bind fsk_message_assembler fsk_asm_props u_fsk_asm_props (.*);

// file: sim/fsk_modulator_model.sv
// Modulator model: baud ticks and bit capture
`timescale 1ns/1ns
module fsk_modulator_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Baud period in cycles, minus one
  input wire logic [3:0] div,
  // Assembler stream
  input wire logic bit_out,
  input wire logic bit_valid,
  output logic baud_tick,
  // Captured bit for the bench
  output logic got_bit,
  output logic got_val
);
  logic [3:0] cnt_q; // Cycles since last tick
  // Free-running ticks, as a real modem keeps its baud clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= (cnt_q >= div);
      cnt_q <= (cnt_q >= div) ? 4'h0 : cnt_q + 4'h1;
    end
  end
  // Take the presented bit at each tick edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_bit <= 1'b0;
      got_val <= 1'b1;
    end else begin
      got_bit <= baud_tick && bit_valid;
      got_val <= bit_out;
    end
  end
endmodule

// file: sim/fsk_message_assembler_test.sv
// Self-checking bench for the FSK message assembler
`timescale 1ns/1ns
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin n_mismatch++; \
  $display("ERROR %0t: got %h exp %h", $time, g, x); end end
module fsk_message_assembler_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic off_hook_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, baud_tick, bit_out, bit_valid, got_bit, got_val;
  logic er, eb, ck_on = 1'b0, dup_on = 1'b0;
  logic [3:0] div = 4'h1; // Modulator pace
  logic q[$]; // Expected stream bits, oldest first
  logic [7:0] sum = 8'h00, b, ev;
  int n_mismatch = 0, n_tests = 0, nstop = 1, n;
  always #20 pclk = ~pclk;
  fsk_message_assembler u_fsk_message_assembler (.ce(1'b1), .*);
  fsk_modulator_model u_fsk_modulator_model (.*);
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Each captured bit against the oldest note
  always @(posedge pclk) begin
    if (got_bit === 1'b1) begin
      eb = (q.size() == 0) ? ~got_val : q.pop_front();
      `CHK(got_val, eb)
    end
  end
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 9000; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 9000) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // Command word write
  task automatic cmd(input logic [4:0] op, input logic [1:0] g,
      input logic [1:0] s, input logic [16:0] d);
    apb(1'b1, fsk_asm_pkg::CMD_OFFSET, {op, g, s, 6'h00, d}, rd, er);
    `CHK(er, 1'b0)
  endtask
  // Unguarded command with selector zero
  task automatic cmd0(input logic [4:0] op, input logic [16:0] d);
    cmd(op, 2'h0, 2'h0, d);
  endtask
  // Note one framed byte, with its copy when it matches the repeat value
  task automatic ebyte(input logic [7:0] v, input logic ck);
    repeat ((dup_on && v == b && !ck) ? 2 : 1) begin
      q.push_back(1'b0);
      for (int j = 0; j < 8; j++) q.push_back(v[j]);
      repeat (nstop) q.push_back(1'b1);
    end
    if (ck_on && !ck) sum = sum + v;
  endtask
  // Wait until every noted bit came out
  task automatic drain(input string t);
    for (int k = 0; k < 9000 && q.size() != 0; k++) @(posedge pclk);
    if (q.size() != 0) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (4) @(posedge pclk);
    $display("Test %s done", t);
  endtask
  // Main sequence
  initial begin
    void'($urandom(52190));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, fsk_asm_pkg::STATUS_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'h0)
    apb(1'b0, fsk_asm_pkg::CONFIG_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'h1)
    apb(1'b0, 8'h10, 32'h0, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, fsk_asm_pkg::STATUS_OFFSET, 32'h0, rd, er);
    `CHK(er, 1'b1)
    drain("registers");
    nstop = 2;
    cmd0(fsk_asm_pkg::OP_STOPBITS, 17'h2);
    cmd0(fsk_asm_pkg::OP_CK_MOD, 17'h0);
    cmd0(fsk_asm_pkg::OP_CK_CLEAR, 17'h0);
    cmd0(fsk_asm_pkg::OP_CK_ON, 17'h0);
    ck_on = 1'b1;
    b = 8'($urandom);
    ebyte(8'h80, 1'b0);
    cmd(fsk_asm_pkg::OP_MESSAGE, 2'h0, fsk_asm_pkg::SEL_START, 17'h80);
    ebyte(b, 1'b0);
    cmd0(fsk_asm_pkg::OP_BYTE, {9'h0, b});
    ebyte(8'h56, 1'b0);
    ebyte(8'h34, 1'b0);
    cmd0(fsk_asm_pkg::OP_TWO_BYTE, 17'h3456);
    ebyte(8'hAB, 1'b0);
    ebyte(8'hCD, 1'b0);
    cmd0(fsk_asm_pkg::OP_BYTE, 17'h1ABCD);
    ebyte(8'h07, 1'b0);
    cmd(fsk_asm_pkg::OP_BYTE, 2'h0, fsk_asm_pkg::SEL_WHOLE, 17'h2);
    ebyte(8'h06, 1'b0);
    ebyte(8'h00, 1'b0);
    cmd(fsk_asm_pkg::OP_TWO_BYTE, 2'h0, fsk_asm_pkg::SEL_WHOLE, 17'h0);
    ebyte(8'h00 - sum, 1'b1);
    cmd0(fsk_asm_pkg::OP_CK_ADD, 17'h0);
    drain("frame");
    apb(1'b0, fsk_asm_pkg::LENGTH_OFFSET, 32'h0, rd, er);
    `CHK(rd, 32'h8)
    cmd0(fsk_asm_pkg::OP_CK_OFF, 17'h0);
    ck_on = 1'b0;
    nstop = 1;
    cmd0(fsk_asm_pkg::OP_STOPBITS, 17'h1);
    cmd0(fsk_asm_pkg::OP_CK_LOAD, 17'h5);
    cmd0(fsk_asm_pkg::OP_CK_INC, 17'h3);
    cmd0(fsk_asm_pkg::OP_CK_DEC, 17'h1);
    ebyte(8'hF9, 1'b1);
    cmd0(fsk_asm_pkg::OP_CK_ADD, 17'h0);
    cmd0(fsk_asm_pkg::OP_CK_CRC, 17'h0);
    cmd0(fsk_asm_pkg::OP_CK_LOAD, 17'h1234);
    ebyte(8'h34, 1'b1);
    ebyte(8'h12, 1'b1);
    cmd0(fsk_asm_pkg::OP_CK_ADD, 17'h0);
    cmd0(fsk_asm_pkg::OP_CK_CLEAR, 17'h0);
    ebyte(8'h00, 1'b1);
    ebyte(8'h00, 1'b1);
    cmd0(fsk_asm_pkg::OP_CK_ADD, 17'h0);
    cmd0(fsk_asm_pkg::OP_CK_MOD, 17'h0);
    drain("checksum");
    div <= 4'h0;
    for (int m = 0; m < 3; m++) begin
      n = $urandom_range(1, 7);
      for (int j = 0; j < n; j++) q.push_back(m == 0 || m == 2 && j[0]);
      cmd(fsk_asm_pkg::OP_BITS, 2'h0, m[1:0], 17'(n));
    end
    cmd0(fsk_asm_pkg::OP_BITS, 17'h0);
    drain("runs");
    for (int p = 0; p < 2; p++) begin
      off_hook_pin <= p[0];
      repeat (8) @(posedge pclk);
      q.push_back(1'b0);
      cmd(fsk_asm_pkg::OP_BITS, p[0] ? 2'h1 : 2'h2, 2'h0, 17'h2);
      cmd(fsk_asm_pkg::OP_BITS, p[0] ? 2'h2 : 2'h1, 2'h1, 17'h1);
      drain("guard");
    end
    div <= 4'h3;
    for (int m = 2; m >= 0; m--) begin
      b = 8'($urandom_range(32, 122));
      ev = m == 1 ? {~^b[6:0], b[6:0]} : m == 2 ? {^b[6:0], b[6:0]} : b;
      cmd0(fsk_asm_pkg::OP_PARITY, 17'(m));
      ebyte(ev, 1'b1);
      cmd0(fsk_asm_pkg::OP_CHAR, {9'h0, b});
    end
    drain("parity");
    b = 8'h10;
    dup_on = 1'b1;
    cmd(fsk_asm_pkg::OP_DUPLICATE, 2'h0, 2'h1, 17'h10);
    ebyte(8'h10, 1'b0);
    cmd0(fsk_asm_pkg::OP_BYTE, 17'h10);
    ebyte(8'h11, 1'b0);
    cmd0(fsk_asm_pkg::OP_BYTE, 17'h11);
    cmd0(fsk_asm_pkg::OP_CK_LOAD, 17'hF0);
    ebyte(8'h10, 1'b1);
    cmd0(fsk_asm_pkg::OP_CK_ADD, 17'h0);
    cmd0(fsk_asm_pkg::OP_DUPLICATE, 17'h0);
    dup_on = 1'b0;
    ebyte(8'h10, 1'b0);
    cmd0(fsk_asm_pkg::OP_BYTE, 17'h10);
    drain("repeat");
    tally_and_finish();
  end
endmodule
